//--- include/sesft_pkg.sv
// constants for the sensor event status and fifo trigger block
// assumes one ref_clk domain and a register port fed by the serial decoder
// Behaviour
// - in trigger mode, an enabled source flag rising freezes fifo sample storage
// - trigger config has five separate enables, all reset to zero
// - gate error flag sets on a detected gate error, clears when fifo empties
// - five-bit elapsed field counts odr periods since gate error, zeroed on clear
// - mode field always tracks the current operating mode
// - eight source bits read one when their function asserted, reset zero
// - source register read clears only the vector-magnitude bit
// - sleep-wake bit sets on a transition event, clears on mode register read
// - enter sleep after inactivity beyond limit, wake on selected event
// - fifo bit sets on overflow or watermark, clears on fifo status read
// - transient bit sets on event-active with enable, clears on its source read
// - orientation bit sets on change with enable, clears on orientation status read
// - tap bit sets on pulse event-active with enable, clears on pulse source read
// - freefall/motion bit sets on its event-active with enable, clears on its read
// - vector-magnitude bit clears on a read of the source register
// - new-sample bit follows accel or magnetic data, clears on matching data read
package sesft_pkg;
  localparam logic [7:0] SESFT_FTRIG_OFS = 8'h0a;
  localparam logic [7:0] SESFT_MODE_STAT_OFS = 8'h0b;
  localparam logic [7:0] SESFT_INT_SRC_OFS = 8'h0c;
  localparam logic [7:0] SESFT_FTRIG_RST = 8'h00;
  localparam logic [7:0] SESFT_INT_SRC_RST = 8'h00;
  localparam logic [7:0] SESFT_TRIG_MASK = 8'h3e;
  // source bit positions; trigger enables share positions 5..1
  localparam int SESFT_B_ASLP = 7;
  localparam int SESFT_B_FIFO = 6;
  localparam int SESFT_B_TRANS = 5;
  localparam int SESFT_B_ORIENT = 4;
  localparam int SESFT_B_PULSE = 3;
  localparam int SESFT_B_FFMT = 2;
  localparam int SESFT_B_AVECM = 1;
  localparam int SESFT_B_DRDY = 0;
  localparam int SESFT_B_FGERR = 7;
  localparam int SESFT_FGT_LSB = 2;
  localparam int SESFT_FGT_W = 5;
  localparam logic [4:0] SESFT_FGT_MAX = 5'h1f;
  localparam logic [1:0] SESFT_MODE_STANDBY = 2'h0;
  localparam logic [1:0] SESFT_MODE_WAKE = 2'h1;
  localparam logic [1:0] SESFT_MODE_SLEEP = 2'h2;
  localparam int SESFT_ASLP_CNT_W = 8;
  typedef enum logic [2:0] {
    SESFT_ST_STANDBY = 3'b001,
    SESFT_ST_WAKE = 3'b010,
    SESFT_ST_SLEEP = 3'b100
  } sesft_state_t;
endpackage

//--- include/sesft_mode_if.sv
// signals between the status logic and the auto-sleep mode tracker
// assumes both ends run on ref_clk
`timescale 1ns/1ns
`default_nettype none
interface sesft_mode_if #(parameter int CNT_W = 8);
  logic active;
  logic auto_sleep_en;
  logic [CNT_W-1:0] aslp_limit;
  logic odr_tick;
  logic wake_event;
  logic [1:0] mode;
  logic aslp_evt;
  logic in_sleep;
  modport ctrl (output active, auto_sleep_en, aslp_limit, odr_tick, wake_event,
    input mode, aslp_evt, in_sleep);
  modport tracker (input active, auto_sleep_en, aslp_limit, odr_tick, wake_event,
    output mode, aslp_evt, in_sleep);
endinterface
`default_nettype wire

//--- src/sesft_mode.sv
// auto-sleep / auto-wake mode tracker
// assumes odr_tick is a one-cycle pulse per output-data-rate period
`timescale 1ns/1ns
`default_nettype none
module sesft_mode import sesft_pkg::*; #(
  parameter int CNT_W = SESFT_ASLP_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sesft_mode_if.tracker mif
);
  sesft_state_t state, next_state;
  logic [CNT_W-1:0] idle_cnt, next_idle_cnt;
  logic [1:0] next_mode;
  logic next_aslp_evt;

  always_comb begin
    next_state = state;
    next_idle_cnt = idle_cnt;
    next_aslp_evt = 1'b0;
    unique case (state)
      SESFT_ST_STANDBY: begin
        next_idle_cnt = '0;
        if (mif.active) next_state = SESFT_ST_WAKE;
      end
      SESFT_ST_WAKE: begin
        if (mif.wake_event || !mif.auto_sleep_en) begin
          next_idle_cnt = '0;
        end else if (idle_cnt > mif.aslp_limit) begin
          next_state = SESFT_ST_SLEEP;
          next_aslp_evt = 1'b1;
          next_idle_cnt = '0;
        end else if (mif.odr_tick && idle_cnt != '1) begin
          next_idle_cnt = idle_cnt + 1'b1;
        end
      end
      SESFT_ST_SLEEP: begin
        if (mif.wake_event) begin
          next_state = SESFT_ST_WAKE;
          next_aslp_evt = 1'b1;
        end
      end
      default: next_state = SESFT_ST_STANDBY;
    endcase
    // standby overrides everything, a transition event is not raised for it
    if (!mif.active) begin
      next_state = SESFT_ST_STANDBY;
      next_aslp_evt = 1'b0;
    end
    unique case (next_state)
      SESFT_ST_WAKE: next_mode = SESFT_MODE_WAKE;
      SESFT_ST_SLEEP: next_mode = SESFT_MODE_SLEEP;
      default: next_mode = SESFT_MODE_STANDBY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SESFT_ST_STANDBY;
      idle_cnt <= '0;
      mif.mode <= SESFT_MODE_STANDBY;
      mif.aslp_evt <= 1'b0;
      mif.in_sleep <= 1'b0;
    end else begin
      state <= next_state;
      idle_cnt <= next_idle_cnt;
      mif.mode <= next_mode;
      mif.aslp_evt <= next_aslp_evt;
      mif.in_sleep <= (next_state == SESFT_ST_SLEEP);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_mode_standby;
    !mif.active |=> mif.mode == SESFT_MODE_STANDBY;
  endproperty
  a_mode_standby: assert property (p_mode_standby) else $error("mode not standby");
  property p_mode_legal;
    mif.mode != 2'h3 && (mif.in_sleep == (mif.mode == SESFT_MODE_SLEEP));
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("mode code bad");
  property p_sleep_enter;
    state == SESFT_ST_WAKE && mif.active && mif.auto_sleep_en && !mif.wake_event
      && idle_cnt > mif.aslp_limit |=> mif.mode == SESFT_MODE_SLEEP && mif.aslp_evt;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("no sleep entry");
  property p_wake_return;
    state == SESFT_ST_SLEEP && mif.active && mif.wake_event |=> mif.mode == SESFT_MODE_WAKE;
  endproperty
  a_wake_return: assert property (p_wake_return) else $error("no wake return");
  c_sleep: cover property (state == SESFT_ST_SLEEP && mif.wake_event);
endmodule
`default_nettype wire

//--- src/sesft_top.sv
// event status, system mode and fifo trigger logic of the motion sensor
// assumes register strobes, detector flags and read strobes all come from ref_clk logic
`timescale 1ns/1ns
`default_nettype none
module sesft_top import sesft_pkg::*; #(
  parameter int CNT_W = SESFT_ASLP_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic active_req,
  input wire logic auto_sleep_en,
  input wire logic [CNT_W-1:0] aslp_limit,
  input wire logic odr_tick,
  input wire logic wake_event,
  input wire logic fifo_trig_mode,
  input wire logic fifo_gate_err,
  input wire logic fifo_empty,
  input wire logic fifo_evt,
  input wire logic trans_event_active,
  input wire logic trans_int_en,
  input wire logic orient_newlp,
  input wire logic orient_int_en,
  input wire logic pulse_event_active,
  input wire logic pulse_int_en,
  input wire logic ffmt_event_active,
  input wire logic ffmt_int_en,
  input wire logic a_vecm_evt,
  input wire logic a_vecm_int_en,
  input wire logic accel_drdy,
  input wire logic mag_drdy,
  input wire logic mag_or_hybrid,
  input wire logic rd_fifo_status,
  input wire logic rd_trans_src,
  input wire logic rd_orientation_status_reg,
  input wire logic rd_pulse_src,
  input wire logic rd_ffmt_src,
  input wire logic rd_accel_data,
  input wire logic rd_mag_data,
  output logic fifo_freeze,
  output logic [7:0] int_source,
  output logic sleep_rate_sel
);
  sesft_mode_if #(.CNT_W(CNT_W)) mif ();

  assign mif.active = active_req;
  assign mif.auto_sleep_en = auto_sleep_en;
  assign mif.aslp_limit = aslp_limit;
  assign mif.odr_tick = odr_tick;
  assign mif.wake_event = wake_event;

  sesft_mode #(.CNT_W(CNT_W)) u_mode (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mif(mif.tracker)
  );

  logic [7:0] fifo_trig_en, next_fifo_trig_en;
  logic fgerr, next_fgerr;
  logic [SESFT_FGT_W-1:0] fgt, next_fgt;
  logic [7:0] next_int_source, set_v, clr_v;
  logic next_fifo_freeze;
  logic [7:0] next_reg_rdata;
  logic rd_mode_stat, rd_int_src;

  // register port
  always_comb begin
    rd_mode_stat = reg_rd && reg_addr == SESFT_MODE_STAT_OFS;
    rd_int_src = reg_rd && reg_addr == SESFT_INT_SRC_OFS;
    next_fifo_trig_en = fifo_trig_en;
    if (reg_wr && reg_addr == SESFT_FTRIG_OFS) begin
      next_fifo_trig_en = reg_wdata & SESFT_TRIG_MASK;
    end
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        SESFT_FTRIG_OFS: next_reg_rdata = fifo_trig_en;
        SESFT_MODE_STAT_OFS: next_reg_rdata = {fgerr, fgt, mif.mode};
        SESFT_INT_SRC_OFS: next_reg_rdata = int_source;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  // source flags: set wins over a clear in the same cycle
  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[SESFT_B_ASLP] = mif.aslp_evt;
    clr_v[SESFT_B_ASLP] = rd_mode_stat;
    set_v[SESFT_B_FIFO] = fifo_evt;
    clr_v[SESFT_B_FIFO] = rd_fifo_status;
    set_v[SESFT_B_TRANS] = trans_event_active && trans_int_en;
    clr_v[SESFT_B_TRANS] = rd_trans_src;
    set_v[SESFT_B_ORIENT] = orient_newlp && orient_int_en;
    clr_v[SESFT_B_ORIENT] = rd_orientation_status_reg;
    set_v[SESFT_B_PULSE] = pulse_event_active && pulse_int_en;
    clr_v[SESFT_B_PULSE] = rd_pulse_src;
    set_v[SESFT_B_FFMT] = ffmt_event_active && ffmt_int_en;
    clr_v[SESFT_B_FFMT] = rd_ffmt_src;
    set_v[SESFT_B_AVECM] = a_vecm_evt && a_vecm_int_en;
    clr_v[SESFT_B_AVECM] = rd_int_src;
    // in hybrid the magnetic readout is the one that drains the new-sample flag
    set_v[SESFT_B_DRDY] = mag_or_hybrid ? mag_drdy : accel_drdy;
    clr_v[SESFT_B_DRDY] = mag_or_hybrid ? rd_mag_data : rd_accel_data;
    next_int_source = set_v | (int_source & ~clr_v);
  end

  // trigger gate and gate error timer
  always_comb begin
    next_fifo_freeze = fifo_freeze;
    // only a flag that newly sets gates the fifo, stale flags do not re-arm it
    if (fifo_trig_mode && |(fifo_trig_en & set_v & ~int_source)) begin
      next_fifo_freeze = 1'b1;
    end else if (!fifo_trig_mode) begin
      next_fifo_freeze = 1'b0;
    end
    next_fgerr = fgerr;
    next_fgt = fgt;
    if (fifo_gate_err) begin
      next_fgerr = 1'b1;
    end else if (fifo_empty) begin
      next_fgerr = 1'b0;
    end
    if (!next_fgerr) begin
      next_fgt = '0;
    end else if (fgerr && odr_tick && fgt != SESFT_FGT_MAX) begin
      next_fgt = fgt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_trig_en <= SESFT_FTRIG_RST;
      int_source <= SESFT_INT_SRC_RST;
      fgerr <= 1'b0;
      fgt <= '0;
      fifo_freeze <= 1'b0;
      reg_rdata <= 8'h00;
      sleep_rate_sel <= 1'b0;
    end else begin
      fifo_trig_en <= next_fifo_trig_en;
      int_source <= next_int_source;
      fgerr <= next_fgerr;
      fgt <= next_fgt;
      fifo_freeze <= next_fifo_freeze;
      reg_rdata <= next_reg_rdata;
      sleep_rate_sel <= mif.in_sleep;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_trig_freeze;
    fifo_trig_mode && |(fifo_trig_en & set_v & ~int_source) |=> fifo_freeze;
  endproperty
  a_trig_freeze: assert property (p_trig_freeze) else $error("fifo not gated");
  property p_trig_mask;
    (fifo_trig_en & ~SESFT_TRIG_MASK) == 8'h00;
  endproperty
  a_trig_mask: assert property (p_trig_mask) else $error("trigger reserved bit set");
  property p_fgerr_set;
    fifo_gate_err |=> fgerr && (fgt == 5'h00 || $past(fgerr));
  endproperty
  a_fgerr_set: assert property (p_fgerr_set) else $error("gate error not flagged");
  property p_fgerr_clr;
    fgerr && fifo_empty && !fifo_gate_err |=> !fgerr && fgt == 5'h00;
  endproperty
  a_fgerr_clr: assert property (p_fgerr_clr) else $error("gate error not cleared");
  property p_fgt_count;
    fgerr && !fifo_gate_err && !fifo_empty && odr_tick && fgt != SESFT_FGT_MAX
      |=> fgt == $past(fgt) + 5'h01;
  endproperty
  a_fgt_count: assert property (p_fgt_count) else $error("elapsed count wrong");
  property p_read_keeps;
    rd_int_src && (clr_v & 8'hfd) == 8'h00
      |=> (($past(int_source) & ~int_source) & 8'hfd) == 8'h00;
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("source read cleared a flag");
  property p_avecm_clr;
    rd_int_src && !set_v[SESFT_B_AVECM] |=> !int_source[SESFT_B_AVECM];
  endproperty
  a_avecm_clr: assert property (p_avecm_clr) else $error("vecm bit kept");
  property p_aslp_clr;
    rd_mode_stat && !mif.aslp_evt |=> !int_source[SESFT_B_ASLP];
  endproperty
  a_aslp_clr: assert property (p_aslp_clr) else $error("sleep-wake bit kept");
  property p_fifo_bit;
    fifo_evt |=> int_source[SESFT_B_FIFO];
  endproperty
  a_fifo_bit: assert property (p_fifo_bit) else $error("fifo bit not set");
  property p_trans_bit;
    trans_event_active && trans_int_en |=> int_source[SESFT_B_TRANS];
  endproperty
  a_trans_bit: assert property (p_trans_bit) else $error("transient bit not set");
  property p_orient_bit;
    orient_newlp && orient_int_en |=> int_source[SESFT_B_ORIENT];
  endproperty
  a_orient_bit: assert property (p_orient_bit) else $error("orientation bit not set");
  property p_pulse_bit;
    rd_pulse_src && !(pulse_event_active && pulse_int_en) |=> !int_source[SESFT_B_PULSE];
  endproperty
  a_pulse_bit: assert property (p_pulse_bit) else $error("tap bit kept");
  property p_ffmt_bit;
    ffmt_event_active && ffmt_int_en |=> int_source[SESFT_B_FFMT];
  endproperty
  a_ffmt_bit: assert property (p_ffmt_bit) else $error("motion bit not set");
  property p_drdy_bit;
    mag_or_hybrid && rd_mag_data && !mag_drdy |=> !int_source[SESFT_B_DRDY];
  endproperty
  a_drdy_bit: assert property (p_drdy_bit) else $error("new-sample bit kept");
  c_freeze: cover property (!fifo_freeze ##1 fifo_freeze);
  c_fgt_sat: cover property (fgt == SESFT_FGT_MAX);
  c_set_clr: cover property (|(set_v & clr_v));
endmodule
`default_nettype wire

//--- test/sesft_host.sv
// host model: single-byte register reads and writes over the port
// assumes the block takes reg_wr/reg_rd on the rising edge of ref_clk
`timescale 1ns/1ns
`default_nettype none
module sesft_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobe lasts one cycle; address and data hold past the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // rdata is registered, so it is taken one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- test/sesft_top_tb_top.sv
// self-checking bench for the event status and fifo trigger block
// assumes the host model drives the register port; the bench drives detectors
`timescale 1ns/1ns
`default_nettype none
module sesft_top_tb_top import sesft_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  // strobes: 0..3 ffmt/pulse/orient/trans set, 4..7 their clears, 8.. misc
  logic [17:0] st = '0;
  logic [4:0] en = '0;
  logic act = 1'b0, asen = 1'b0, tmode = 1'b0, fempty = 1'b0, hyb = 1'b0;
  logic [7:0] aslp_limit = 8'h02;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, int_source, rd_val;
  logic reg_wr, reg_rd, fifo_freeze, sleep_rate_sel;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  sesft_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  sesft_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_req(act), .auto_sleep_en(asen), .aslp_limit(aslp_limit),
    .odr_tick(st[16]), .wake_event(st[17]), .fifo_trig_mode(tmode),
    .fifo_gate_err(st[15]), .fifo_empty(fempty), .fifo_evt(st[13]),
    .trans_event_active(st[3]), .trans_int_en(en[3]), .orient_newlp(st[2]),
    .orient_int_en(en[2]), .pulse_event_active(st[1]), .pulse_int_en(en[1]),
    .ffmt_event_active(st[0]), .ffmt_int_en(en[0]), .a_vecm_evt(st[8]),
    .a_vecm_int_en(en[4]), .accel_drdy(st[9]), .mag_drdy(st[11]), .mag_or_hybrid(hyb),
    .rd_fifo_status(st[14]), .rd_trans_src(st[7]), .rd_orientation_status_reg(st[6]),
    .rd_pulse_src(st[5]), .rd_ffmt_src(st[4]), .rd_accel_data(st[10]),
    .rd_mag_data(st[12]), .fifo_freeze(fifo_freeze), .int_source(int_source),
    .sleep_rate_sel(sleep_rate_sel));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle strobe; outputs are looked at just after the edge that took it
  task automatic pulse(input int b);
    @(posedge ref_clk);
    st[b] <= 1'b1;
    @(posedge ref_clk);
    st[b] <= 1'b0;
    #1;
  endtask
  task automatic flag(input int s, input int c, input int b);
    pulse(s);
    chk(int_source[b], 1'b1);
    pulse(c);
    chk(int_source[b], 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_regs;
    host.rd(SESFT_FTRIG_OFS, rd_val);
    chk(rd_val, SESFT_FTRIG_RST);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h00);
    host.rd(SESFT_INT_SRC_OFS, rd_val);
    chk(rd_val, SESFT_INT_SRC_RST);
    host.wr(SESFT_FTRIG_OFS, 8'hff);
    host.rd(SESFT_FTRIG_OFS, rd_val);
    chk(rd_val, 8'h3e);
    host.rd(8'h55, rd_val);
    chk(rd_val, 8'h00);
    host.wr(SESFT_INT_SRC_OFS, 8'hff);
    host.rd(SESFT_INT_SRC_OFS, rd_val);
    chk(rd_val, 8'h00);
    $display("register test done");
  endtask
  task automatic t_flags;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      chk(int_source, 8'h00);
      @(posedge ref_clk) en[i] <= 1'b1;
      pulse(i);
      chk(int_source[i+2], 1'b1);
      host.rd(SESFT_INT_SRC_OFS, rd_val);
      chk(rd_val[i+2], 1'b1);
      chk(int_source[i+2], 1'b1);
      pulse(i + 4);
      chk(int_source[i+2], 1'b0);
    end
    @(posedge ref_clk) en[4] <= 1'b1;
    pulse(8);
    host.rd(SESFT_INT_SRC_OFS, rd_val);
    chk(rd_val[1], 1'b1);
    chk(int_source[1], 1'b0);
    flag(9, 10, SESFT_B_DRDY);
    flag(13, 14, SESFT_B_FIFO);
    @(posedge ref_clk) hyb <= 1'b1;
    pulse(9);
    chk(int_source[0], 1'b0);
    flag(11, 12, SESFT_B_DRDY);
    @(posedge ref_clk) hyb <= 1'b0;
    $display("flag test done");
  endtask
  task automatic t_trig;
    host.wr(SESFT_FTRIG_OFS, 8'h20);
    tmode <= 1'b1;
    pulse(0);
    wt(2);
    chk(fifo_freeze, 1'b0);
    pulse(3);
    wt(2);
    chk(fifo_freeze, 1'b1);
    pulse(4);
    pulse(7);
    chk(fifo_freeze, 1'b1);
    @(posedge ref_clk) tmode <= 1'b0;
    wt(2);
    chk(fifo_freeze, 1'b0);
    $display("trigger test done");
  endtask
  task automatic t_gate;
    pulse(15);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h80);
    repeat (3) pulse(16);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h8c);
    @(posedge ref_clk) fempty <= 1'b1;
    @(posedge ref_clk) fempty <= 1'b0;
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h00);
    $display("gate error test done");
  endtask
  task automatic t_mode;
    @(posedge ref_clk) act <= 1'b1;
    wt(2);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h01);
    @(posedge ref_clk) asen <= 1'b1;
    // two ticks equal the limit, which must not yet count as exceeding it
    repeat (2) pulse(16);
    wt(4);
    chk(int_source[7], 1'b0);
    pulse(16);
    wt(4);
    chk(int_source[7], 1'b1);
    chk(sleep_rate_sel, 1'b1);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h02);
    chk(int_source[7], 1'b0);
    pulse(17);
    wt(4);
    chk(int_source[7], 1'b1);
    chk(sleep_rate_sel, 1'b0);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h01);
    @(posedge ref_clk) act <= 1'b0;
    wt(2);
    host.rd(SESFT_MODE_STAT_OFS, rd_val);
    chk(rd_val, 8'h00);
    chk(int_source[7], 1'b0);
    $display("mode test done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_flags;
    t_trig;
    t_gate;
    t_mode;
    test_done;
  end
  // far beyond the roughly 170 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    test_done;
  end
endmodule
`default_nettype wire
